// ---- hdl/asp_pkg.sv ----
package asp_pkg;

  localparam int FRAME_BITS = 16;
  localparam int CTRL_BITS = 5;
  localparam int CODE_BITS = 12;
  localparam int CHAN_BITS = 3;
  localparam int CHAN_LSB = 2;
  localparam int SETTLE_BITS = 16;

  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_TIME_NS = 5900;
  localparam int CONV_CYCLES_RAW = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
  localparam int SCLK_HALF_DEF = 5;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_CFG = 12'h004;
  localparam logic [11:0] ADDR_SETTLE = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_RESULT = 12'h010;

  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] SETTLE_RST = 16'h0040;
  localparam logic CFG_BIPOLAR_RST = 1'b0;

  localparam int ST_WAIT = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_HOLD = 2;
  localparam int ST_SETTLE = 3;
  localparam int ST_FRAME_REQ = 4;
  localparam int ST_SLAVE = 5;
  localparam int ST_BITS = 6;

  typedef enum logic [2:0] {
    CV_IDLE = 3'b001,
    CV_WAIT = 3'b010,
    CV_CONV = 3'b100
  } asp_conv_e;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b01,
    MS_SHIFT = 2'b10
  } asp_mst_e;

endpackage

// ---- hdl/asp_core.sv ----
// How it works
// - Role select low: device drives shift clock and receive frame strobe.
// - Role select high: host supplies shift clock and receive frame strobe.
// - Trigger rising edge enters hold and starts conversion once settling ended.
// - Trigger during settling pulse defers hold and conversion until pulse ends.
// - Settling pulse length follows the delay capacitor setting register.
// - Master clock runs the whole conversion sequence.
// - Master mode shift clock is divided down from the master clock.
// - Active shift clock both loads control bits and shifts out results.
// - Master mode device generates and drives the receive frame strobe.
// - Frame is a zero, three channel bits, then twelve result bits.
// - Output bits are valid on sixteen falling edges after strobe falls.
// - Result is two's complement when bipolar, else straight binary.
// - First five input bits after strobe falls enter the control register.
// - Further input bits are ignored while transmit strobe stays low.
// - Three channel bits of the control register select the input channel.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module asp_core
  import asp_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_role_select,
  input wire logic conversion_trigger,
  input wire logic [CODE_BITS-1:0] analog_code,
  input wire logic link_sclk,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic transmit_frame_strobe_n,
  input wire logic receive_frame_strobe_n_in,
  output logic receive_frame_strobe_n_out,
  output logic receive_frame_strobe_oe,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic channel_select_bit0,
  output logic channel_select_bit1,
  output logic channel_select_bit2,
  output logic track_hold_hold,
  output logic conv_busy
);

  // The divider counter is eight bits wide
  if (SCLK_HALF < 1 || SCLK_HALF > 255)
  begin : g_half_check
    $error("asp_core: SCLK_HALF out of range");
  end

  function automatic logic [FRAME_BITS-1:0] build_frame(input logic [CHAN_BITS-1:0] chan,
                                                        input logic [CODE_BITS-1:0] code,
                                                        input logic bipolar);
    logic [CODE_BITS-1:0] coded;
    coded = bipolar ? {~code[CODE_BITS-1], code[CODE_BITS-2:0]} : code;
    return {1'b0, chan, coded};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers into the master clock domain

  logic [1:0] mode_sync_reg;
  logic [1:0] trig_sync_reg;
  logic [1:0] tfs_sync_reg;
  logic [1:0] din_sync_reg;
  logic [1:0] ctgl_sync_reg;
  logic trig_prev_reg;
  logic ctgl_seen_reg;
  logic lk_ctgl_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_sync_reg <= 2'h3;
      trig_sync_reg <= 2'h0;
      tfs_sync_reg <= 2'h3;
      din_sync_reg <= 2'h0;
      ctgl_sync_reg <= 2'h0;
      trig_prev_reg <= 1'b0;
      ctgl_seen_reg <= 1'b0;
    end
    else
    begin
      mode_sync_reg <= {mode_sync_reg[0], serial_role_select};
      trig_sync_reg <= {trig_sync_reg[0], conversion_trigger};
      tfs_sync_reg <= {tfs_sync_reg[0], transmit_frame_strobe_n};
      din_sync_reg <= {din_sync_reg[0], serial_data_in};
      ctgl_sync_reg <= {ctgl_sync_reg[0], lk_ctgl_reg};
      trig_prev_reg <= trig_sync_reg[1];
      ctgl_seen_reg <= ctgl_sync_reg[1];
    end
  end

  wire slave_mode = mode_sync_reg[1];
  wire trig_rise = trig_sync_reg[1] & ~trig_prev_reg;
  // Link deliveries are ignored in master mode, where the pad loops our own clock back
  wire link_ctrl_evt = slave_mode & (ctgl_sync_reg[1] ^ ctgl_seen_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Slave link domain, clocked by the host shift clock

  logic [CTRL_BITS-1:0] lk_ctrl_reg;
  logic [2:0] lk_icnt_reg;
  logic [CTRL_BITS-2:0] lk_ishift_reg;
  logic [4:0] lk_ocnt_reg;
  logic lk_dout_reg;
  logic lk_done_reg;
  logic [FRAME_BITS-1:0] lk_word_reg;
  logic [1:0] lk_rtgl_sync_reg;
  logic lk_rtgl_seen_reg;
  logic [FRAME_BITS-1:0] result_word_reg;
  logic res_tgl_reg;

  // Frame strobes clear their counters, so a stopped clock needs no trailing edge
  wire rfs_clr_n = presetn & ~receive_frame_strobe_n_in;
  wire tfs_clr_n = presetn & ~transmit_frame_strobe_n;

  always_ff @(negedge link_sclk or negedge tfs_clr_n)
  begin
    if (!tfs_clr_n)
    begin
      lk_icnt_reg <= 3'h0;
      lk_ishift_reg <= 4'h0;
    end
    else if (lk_icnt_reg < 3'(CTRL_BITS))
    begin
      lk_ishift_reg <= {lk_ishift_reg[CTRL_BITS-3:0], serial_data_in};
      lk_icnt_reg <= lk_icnt_reg + 3'h1;
    end
  end

  always_ff @(negedge link_sclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lk_ctrl_reg <= CTRL_RST;
      lk_ctgl_reg <= 1'b0;
    end
    else if (!transmit_frame_strobe_n && lk_icnt_reg == 3'(CTRL_BITS - 1))
    begin
      lk_ctrl_reg <= {lk_ishift_reg, serial_data_in};
      lk_ctgl_reg <= ~lk_ctgl_reg;
    end
  end

  // Result word crosses by toggle; taken only between frames so a read never tears
  always_ff @(posedge link_sclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lk_rtgl_sync_reg <= 2'h0;
      lk_rtgl_seen_reg <= 1'b0;
      lk_word_reg <= '0;
    end
    else
    begin
      lk_rtgl_sync_reg <= {lk_rtgl_sync_reg[0], res_tgl_reg};
      if ((lk_rtgl_sync_reg[1] != lk_rtgl_seen_reg) && receive_frame_strobe_n_in)
      begin
        lk_word_reg <= result_word_reg;
        lk_rtgl_seen_reg <= lk_rtgl_sync_reg[1];
      end
    end
  end

  always_ff @(posedge link_sclk or negedge rfs_clr_n)
  begin
    if (!rfs_clr_n)
    begin
      lk_ocnt_reg <= 5'h0;
      lk_dout_reg <= 1'b0;
      lk_done_reg <= 1'b0;
    end
    else if (lk_ocnt_reg < 5'(FRAME_BITS - 1))
    begin
      lk_dout_reg <= lk_word_reg[4'(FRAME_BITS - 2) - lk_ocnt_reg[3:0]];
      lk_ocnt_reg <= lk_ocnt_reg + 5'h1;
    end
    else
      lk_done_reg <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master mode shift clock, frame and control capture

  logic [7:0] div_cnt_reg;
  logic msclk_reg;
  asp_mst_e ms_state_reg;
  logic [4:0] ms_ocnt_reg;
  logic ms_dout_reg;
  logic ms_oe_reg;
  logic ms_rfs_n_reg;
  logic [FRAME_BITS-1:0] ms_word_reg;
  logic [2:0] ms_icnt_reg;
  logic [CTRL_BITS-2:0] ms_ishift_reg;
  logic frame_req_reg;

  wire div_tick = ~slave_mode & (div_cnt_reg == 8'(SCLK_HALF - 1));
  wire ms_fall = div_tick & msclk_reg;
  wire ms_rise = div_tick & ~msclk_reg;
  wire ms_start = (ms_state_reg == MS_IDLE) & frame_req_reg & ms_rise;
  wire ms_take = ms_fall & ~tfs_sync_reg[1] & (ms_icnt_reg < 3'(CTRL_BITS));
  wire mst_ctrl_evt = ms_take & (ms_icnt_reg == 3'(CTRL_BITS - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_reg <= 8'h00;
      msclk_reg <= 1'b1;
    end
    else if (slave_mode)
    begin
      div_cnt_reg <= 8'h00;
      msclk_reg <= 1'b1;
    end
    else if (div_tick)
    begin
      div_cnt_reg <= 8'h00;
      msclk_reg <= ~msclk_reg;
    end
    else
      div_cnt_reg <= div_cnt_reg + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ms_icnt_reg <= 3'h0;
      ms_ishift_reg <= 4'h0;
    end
    else if (tfs_sync_reg[1])
      ms_icnt_reg <= 3'h0;
    else if (ms_take)
    begin
      ms_ishift_reg <= {ms_ishift_reg[CTRL_BITS-3:0], din_sync_reg[1]};
      ms_icnt_reg <= ms_icnt_reg + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ms_state_reg <= MS_IDLE;
      ms_ocnt_reg <= 5'h0;
      ms_dout_reg <= 1'b0;
      ms_oe_reg <= 1'b0;
      ms_rfs_n_reg <= 1'b1;
      ms_word_reg <= '0;
    end
    else
    begin
      case (ms_state_reg)
        MS_IDLE:
        begin
          if (ms_start)
          begin
            ms_state_reg <= MS_SHIFT;
            ms_word_reg <= result_word_reg;
            ms_dout_reg <= result_word_reg[FRAME_BITS-1];
            ms_oe_reg <= 1'b1;
            ms_rfs_n_reg <= 1'b0;
            ms_ocnt_reg <= 5'h0;
          end
        end
        MS_SHIFT:
        begin
          if (slave_mode)
          begin
            ms_state_reg <= MS_IDLE;
            ms_oe_reg <= 1'b0;
            ms_rfs_n_reg <= 1'b1;
          end
          else if (ms_fall)
            ms_ocnt_reg <= ms_ocnt_reg + 5'h1;
          else if (ms_rise && ms_ocnt_reg == 5'(FRAME_BITS))
          begin
            ms_state_reg <= MS_IDLE;
            ms_oe_reg <= 1'b0;
            ms_rfs_n_reg <= 1'b1;
          end
          else if (ms_rise)
            ms_dout_reg <= ms_word_reg[4'(FRAME_BITS - 1) - ms_ocnt_reg[3:0]];
        end
        default:
          ms_state_reg <= MS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register, settling pulse and conversion sequence

  logic [CTRL_BITS-1:0] ctrl_reg;
  logic bipolar_reg;
  logic [SETTLE_BITS-1:0] settle_len_reg;
  logic [SETTLE_BITS-1:0] settle_cnt_reg;
  asp_conv_e cv_state_reg;
  logic [15:0] conv_cnt_reg;
  logic hold_reg;
  logic busy_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  wire apb_acc = psel & penable & ~pready_reg;
  wire apb_wr = psel & penable & pready_reg & pwrite;
  wire sel_ctrl = paddr == ADDR_CTRL;
  wire sel_cfg = paddr == ADDR_CFG;
  wire sel_settle = paddr == ADDR_SETTLE;
  wire sel_status = paddr == ADDR_STATUS;
  wire sel_result = paddr == ADDR_RESULT;
  wire apb_hit = sel_ctrl | sel_cfg | sel_settle | sel_status | sel_result;
  wire apb_ctrl_wr = apb_wr & sel_ctrl;
  wire ctrl_upd = link_ctrl_evt | mst_ctrl_evt | apb_ctrl_wr;
  wire settle_active = settle_cnt_reg != '0;
  wire conv_end = (cv_state_reg == CV_CONV) & (conv_cnt_reg == 16'h0000);
  wire [ST_BITS-1:0] status_word = {slave_mode, frame_req_reg, settle_active, hold_reg, busy_reg,
                                    cv_state_reg == CV_WAIT};
  wire [31:0] rd_mux = sel_ctrl ? 32'(ctrl_reg) :
                       sel_cfg ? 32'(bipolar_reg) :
                       sel_settle ? 32'(settle_len_reg) :
                       sel_status ? 32'(status_word) :
                       sel_result ? 32'(result_word_reg) : 32'h00000000;

  // Serial writes win over a bus write landing in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= CTRL_RST;
    else if (link_ctrl_evt)
      ctrl_reg <= lk_ctrl_reg;
    else if (mst_ctrl_evt)
      ctrl_reg <= {ms_ishift_reg, din_sync_reg[1]};
    else if (apb_ctrl_wr)
      ctrl_reg <= pwdata[CTRL_BITS-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_cnt_reg <= '0;
    else if (ctrl_upd)
      settle_cnt_reg <= settle_len_reg;
    else if (settle_active)
      settle_cnt_reg <= settle_cnt_reg - 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cv_state_reg <= CV_IDLE;
      conv_cnt_reg <= 16'h0000;
      hold_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      case (cv_state_reg)
        CV_IDLE:
        begin
          if (trig_rise && settle_active)
          begin
            cv_state_reg <= CV_WAIT;
            busy_reg <= 1'b1;
          end
          else if (trig_rise)
          begin
            cv_state_reg <= CV_CONV;
            conv_cnt_reg <= 16'(CONV_CYCLES - 1);
            hold_reg <= 1'b1;
            busy_reg <= 1'b1;
          end
        end
        CV_WAIT:
        begin
          if (!settle_active)
          begin
            cv_state_reg <= CV_CONV;
            conv_cnt_reg <= 16'(CONV_CYCLES - 1);
            hold_reg <= 1'b1;
          end
        end
        CV_CONV:
        begin
          if (conv_end)
          begin
            cv_state_reg <= CV_IDLE;
            hold_reg <= 1'b0;
            busy_reg <= 1'b0;
          end
          else
            conv_cnt_reg <= conv_cnt_reg - 16'h0001;
        end
        default:
          cv_state_reg <= CV_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_word_reg <= '0;
      res_tgl_reg <= 1'b0;
    end
    else if (conv_end)
    begin
      result_word_reg <= build_frame(ctrl_reg[CHAN_LSB+CHAN_BITS-1:CHAN_LSB], analog_code, bipolar_reg);
      res_tgl_reg <= ~res_tgl_reg;
    end
  end

  // A new result outranks the frame start that clears the request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_req_reg <= 1'b0;
    else if (conv_end && !slave_mode)
      frame_req_reg <= 1'b1;
    else if (ms_start || slave_mode)
      frame_req_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, write lands on the edge that sees pready

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= apb_acc;
      pslverr_reg <= apb_acc & ~apb_hit;
      if (apb_acc)
        prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bipolar_reg <= CFG_BIPOLAR_RST;
      settle_len_reg <= SETTLE_RST;
    end
    else
    begin
      if (apb_wr && sel_cfg)
        bipolar_reg <= pwdata[0];
      if (apb_wr && sel_settle)
        settle_len_reg <= pwdata[SETTLE_BITS-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  // master drives clock and strobe, slave releases them
  assign sclk_out = msclk_reg;
  assign sclk_oe = ~slave_mode;
  assign receive_frame_strobe_n_out = ms_rfs_n_reg;
  assign receive_frame_strobe_oe = ~slave_mode;
  // released outside frames; slave enable follows the host strobe directly
  assign serial_data_out = slave_mode ? lk_dout_reg : ms_dout_reg;
  assign serial_data_oe = slave_mode ? (~receive_frame_strobe_n_in & ~lk_done_reg) : ms_oe_reg;
  assign channel_select_bit0 = ctrl_reg[CHAN_LSB];
  assign channel_select_bit1 = ctrl_reg[CHAN_LSB+1];
  assign channel_select_bit2 = ctrl_reg[CHAN_LSB+2];
  assign track_hold_hold = hold_reg;
  assign conv_busy = busy_reg;

endmodule

`default_nettype wire

// ---- verif/asp_core_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

module asp_core_properties
  import asp_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic serial_role_select,
  input wire logic conversion_trigger,
  input wire logic link_sclk,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic receive_frame_strobe_n_in,
  input wire logic receive_frame_strobe_n_out,
  input wire logic receive_frame_strobe_oe,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic track_hold_hold,
  input wire logic conv_busy
);
  logic [10:0] hold_cnt;
  logic [7:0] low_cnt;
  logic [4:0] fall_cnt;
  logic sclk_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Run lengths are counted here, since repetitions this long would stall the tools
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_cnt <= 11'h000;
      low_cnt <= 8'h00;
      fall_cnt <= 5'h00;
      sclk_q <= 1'b1;
    end
    else
    begin
      hold_cnt <= track_hold_hold ? hold_cnt + 11'h001 : 11'h000;
      low_cnt <= sclk_out ? 8'h00 : low_cnt + 8'h01;
      fall_cnt <= receive_frame_strobe_n_out ? 5'h00 : fall_cnt + 5'(sclk_q & ~sclk_out);
      sclk_q <= sclk_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_master_drives: assert property (@(posedge pclk) disable iff (!presetn)
    (!serial_role_select) [*4] |-> sclk_oe && receive_frame_strobe_oe) else $error("master pins not driven");
  chk_slave_releases: assert property (@(posedge pclk) disable iff (!presetn)
    serial_role_select [*4] |-> !sclk_oe && !receive_frame_strobe_oe) else $error("slave pins driven");
  chk_start_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(conv_busy) |-> $past(conversion_trigger, 2)) else $error("conversion without trigger");
  chk_hold_in_busy: assert property (@(posedge pclk) disable iff (!presetn)
    track_hold_hold |-> conv_busy) else $error("hold outside busy");
  chk_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(track_hold_hold) |-> hold_cnt == CONV_CYCLES) else $error("conversion length wrong");
  chk_sclk_half: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sclk_out) |-> low_cnt == SCLK_HALF) else $error("shift clock low time wrong");
  chk_frame_edges: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(receive_frame_strobe_n_out) && sclk_oe |-> fall_cnt == 5'd16) else $error("master frame not 16 bits");
  chk_lead_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(receive_frame_strobe_n_out) |-> serial_data_oe && !serial_data_out) else $error("first bit not zero");
  chk_oe_in_frame: assert property (@(posedge pclk) disable iff (!presetn)
    serial_data_oe |-> (sclk_oe ? !receive_frame_strobe_n_out : !receive_frame_strobe_n_in))
    else $error("data driven outside frame");
  chk_slave_valid: assert property (@(negedge link_sclk) disable iff (!presetn)
    !sclk_oe && !receive_frame_strobe_n_in |-> serial_data_oe) else $error("slave data not driven");
endmodule

`default_nettype wire

// ---- verif/asp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module asp_host_model (
  output logic sclk,
  output logic tfs_n,
  output logic rfs_n,
  output logic sdi,
  input wire logic sdo
);
  initial
  begin
    sclk = 1'b1;
    tfs_n = 1'b1;
    rfs_n = 1'b1;
    sdi = 1'b0;
  end

  // host shift clock, 80 ns period
  task automatic tick();
    #40 sclk = 1'b0;
    #40 sclk = 1'b1;
  endtask

  task automatic xfer(input logic [4:0] ctrl, input logic [31:0] junk, output logic [15:0] word);
    // Offset keeps the link edges away from the system clock edges
    #3;
    // Idle edges with the strobes high let a new result cross over
    repeat (3) tick();
    // Strobes fall clear of the last idle rise, so that edge still loads the new result but does not shift
    #20;
    tfs_n = 1'b0;
    rfs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi = (i > 10) ? ctrl[i-11] : junk[i];
      #40 sclk = 1'b0;
      word[i] = sdo;
      #40 sclk = 1'b1;
    end
    tfs_n = 1'b1;
    rfs_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule

`default_nettype wire

// ---- verif/adc_serial_port_and_convert_start_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module adc_serial_port_and_convert_start_test
  import asp_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr, analog_code;
  logic [31:0] pwdata, prdata, seed, q;
  logic serial_role_select, conversion_trigger, sclk_out, sclk_oe, transmit_frame_strobe_n;
  logic receive_frame_strobe_n_out, receive_frame_strobe_oe, serial_data_in, serial_data_out, serial_data_oe;
  logic channel_select_bit0, channel_select_bit1, channel_select_bit2, track_hold_hold, conv_busy;
  logic host_sclk, host_rfs_n, sclk_w, rfs_w, sdo_w, bip;
  logic [15:0] exp_frame, mst_word, word;
  logic [4:0] mst_bits, ctrl;
  int error_cnt, n_checks;

  assign sclk_w = sclk_oe ? sclk_out : host_sclk;
  assign rfs_w = receive_frame_strobe_oe ? receive_frame_strobe_n_out : host_rfs_n;
  // Data line carries a pull-up while nobody drives it
  assign sdo_w = serial_data_oe ? serial_data_out : 1'b1;

  asp_core #(.SCLK_HALF(SCLK_HALF_DEF)) i_asp_core (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .serial_role_select, .conversion_trigger, .analog_code,
    .link_sclk(sclk_w), .sclk_out, .sclk_oe, .transmit_frame_strobe_n, .receive_frame_strobe_n_in(rfs_w),
    .receive_frame_strobe_n_out, .receive_frame_strobe_oe, .serial_data_in, .serial_data_out,
    .serial_data_oe, .channel_select_bit0, .channel_select_bit1, .channel_select_bit2, .track_hold_hold,
    .conv_busy);
  asp_host_model i_host (.sclk(host_sclk), .tfs_n(transmit_frame_strobe_n), .rfs_n(host_rfs_n),
    .sdi(serial_data_in), .sdo(sdo_w));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as it takes; only the watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle: the next call never re-raises psel in this step, and results have settled
    @(posedge pclk);
  endtask

  // Hold level at the edge busy is first seen tells deferral from direct start
  task automatic convert(input logic [11:0] code, input logic hold_exp);
    int n;
    n = 0;
    repeat (4) @(posedge pclk);
    analog_code <= code;
    conversion_trigger <= 1'b1;
    do @(posedge pclk) n++; while (conv_busy !== 1'b1 && n < 200);
    check(track_hold_hold, hold_exp);
    do @(posedge pclk) n++; while (conv_busy !== 1'b0 && n < 1200);
    check(n < 1200, 1);
    conversion_trigger <= 1'b0;
    exp_frame = {1'b0, ctrl[4:2], code ^ {bip, 11'h000}};
  endtask

  always @(negedge sclk_out)
    if (sclk_oe && !receive_frame_strobe_n_out)
    begin
      mst_word = {mst_word[14:0], sdo_w};
      mst_bits++;
    end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial
  begin
    #200000;
    error_cnt++;
    give_verdict();
  end

  initial
  begin
    seed = 32'h00012337;
    {error_cnt, n_checks, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {conversion_trigger, analog_code, mst_bits, mst_word, bip} = '0;
    serial_role_select = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ADDR_SETTLE, 32'h0);
    check(q, 32'h00000040);
    apb(0, ADDR_CTRL, 32'h0);
    check(q, 32'h0);
    apb(1, 12'h020, 32'hFFFFFFFF);
    check(err_q, 1);
    apb(1, ADDR_SETTLE, 32'h00000014);
    // Register path: first pass lands inside the settling pulse
    for (int k = 0; k < 4; k++)
    begin
      ctrl = 5'(rnd());
      bip = k[0];
      apb(1, ADDR_CTRL, {27'h0, ctrl});
      check({channel_select_bit2, channel_select_bit1, channel_select_bit0}, ctrl[4:2]);
      apb(1, ADDR_CFG, {31'h0, bip});
      if (k != 0)
        repeat (24) @(posedge pclk);
      convert(12'(rnd()), k != 0);
      // The link side only takes a new result on idle shift clock edges
      #3 repeat (3) i_host.tick();
      @(posedge pclk);
      apb(0, ADDR_RESULT, 32'h0);
      check(q, exp_frame);
    end
    // Serial path in slave mode: write control, read last result
    for (int k = 0; k < 3; k++)
    begin
      ctrl = 5'(rnd());
      i_host.xfer(ctrl, rnd(), word);
      check(word, exp_frame);
      repeat (10) @(posedge pclk);
      check({channel_select_bit2, channel_select_bit1, channel_select_bit0}, ctrl[4:2]);
      check(serial_data_oe, 0);
      bip = k[0];
      apb(1, ADDR_CFG, {31'h0, bip});
      repeat (30) @(posedge pclk);
      convert(12'(rnd()), 1'b1);
    end
    // Master mode: slave mode leaves no frame request pending, so only wait for the pins to turn
    serial_role_select <= 1'b0;
    repeat (300) @(posedge pclk);
    check({sclk_oe, receive_frame_strobe_oe}, 2'b11);
    mst_bits = 5'h00;
    convert(12'(rnd()), 1'b1);
    repeat (400) @(posedge pclk);
    check(mst_bits, 16);
    check(mst_word, exp_frame);
    give_verdict();
  end
endmodule

bind asp_core asp_core_properties #(.SCLK_HALF(SCLK_HALF)) i_props (.pclk, .presetn, .serial_role_select,
  .conversion_trigger, .link_sclk, .sclk_out, .sclk_oe, .receive_frame_strobe_n_in, .receive_frame_strobe_n_out,
  .receive_frame_strobe_oe, .serial_data_out, .serial_data_oe, .track_hold_hold, .conv_busy);

`default_nettype wire
